/* File: src/fhp_cfg.svh */
// constants for the fault handler priority register block
// assumes a 32-bit apb slave reached by privileged and unprivileged masters
// How it works
// - register reads and writes succeed only for privileged accesses; others error
// - each byte lane is written on its own through the byte strobes
// - bits 23:21 hold a read-write usage-fault level, any value 0 to 7
// - a smaller level is more urgent when the three faults are ranked
// - bits 15:13 hold bus-fault level, bits 7:5 memory-management level
`ifndef FHP_CFG_SVH
`define FHP_CFG_SVH
`define FHP_ADDR_W 12
`define FHP_OFF_PRIO_ONE 12'hd18
`define FHP_RESET_VAL 32'h0000_0000
`define FHP_USAGE_HI 23
`define FHP_USAGE_LO 21
`define FHP_BUS_HI 15
`define FHP_BUS_LO 13
`define FHP_MEM_HI 7
`define FHP_MEM_LO 5
`define FHP_PRIV_BIT 0
`define FHP_LVL_RESET 3'h0
`define FHP_LVL_NONE 3'h7
`endif

/* File: src/fhp_pkg.sv */
// types for the fault handler priority register block
// assumes fhp_cfg.svh supplies the numeric constants
`include "fhp_cfg.svh"
package fhp_pkg;
	typedef logic [2:0] fhp_level_t;
	typedef enum logic [1:0] {
		fhp_src_usage,
		fhp_src_bus,
		fhp_src_mem,
		fhp_src_none
	} fhp_src_t;
endpackage : fhp_pkg

/* File: src/fhp_rank_if.sv */
// carrier between register bank and ranking logic
// assumes one clock domain; pure combinational hand-off
interface fhp_rank_if;
	import fhp_pkg::*;
	fhp_level_t usage_lvl;
	fhp_level_t bus_lvl;
	fhp_level_t mem_lvl;
	logic [2:0] pending;
	fhp_src_t winner;
	fhp_level_t winner_lvl;
	modport bank (output usage_lvl, bus_lvl, mem_lvl, pending, input winner, winner_lvl);
	modport ranker (input usage_lvl, bus_lvl, mem_lvl, pending, output winner, winner_lvl);
endinterface : fhp_rank_if

/* File: src/fhp_rank.sv */
// picks the most urgent pending fault from the three levels
// assumes levels and pending bits come from the register bank
`include "fhp_cfg.svh"
module fhp_rank
	import fhp_pkg::*;
(
	fhp_rank_if.ranker rk // levels in, winner out
);
	// ties resolve usage over bus over mem, a fixed order chosen for determinism
	always_comb begin
		rk.winner = fhp_src_none;
		rk.winner_lvl = `FHP_LVL_NONE;
		if (rk.pending[0]) begin
			rk.winner = fhp_src_usage;
			rk.winner_lvl = rk.usage_lvl;
		end
		if (rk.pending[1] && (rk.winner == fhp_src_none || rk.bus_lvl < rk.winner_lvl)) begin
			rk.winner = fhp_src_bus;
			rk.winner_lvl = rk.bus_lvl;
		end
		if (rk.pending[2] && (rk.winner == fhp_src_none || rk.mem_lvl < rk.winner_lvl)) begin
			rk.winner = fhp_src_mem;
			rk.winner_lvl = rk.mem_lvl;
		end
	end
endmodule : fhp_rank

/* File: src/fhp_top.sv */
// apb slave holding the three fault handler priority levels
// assumes pprot[0] marks a privileged access and pstrb follows apb4
//
// The implementer's own choice: the APB interface to the registers.
`include "fhp_cfg.svh"
module fhp_top
	import fhp_pkg::*;
(
	input wire logic clk_in, // 200 mhz clock
	input wire logic rst_n_in, // async reset, active low
	input wire logic psel_in, // apb select
	input wire logic penable_in, // apb enable
	input wire logic pwrite_in, // apb write
	input wire logic [`FHP_ADDR_W-1:0] paddr_in, // apb byte address
	input wire logic [31:0] pwdata_in, // apb write data
	input wire logic [3:0] pstrb_in, // apb byte strobes
	input wire logic [2:0] pprot_in, // apb protection
	input wire logic [2:0] fault_pend_in, // pending: 0 usage, 1 bus, 2 mem
	output logic [31:0] prdata_out, // apb read data
	output logic pready_out, // apb ready
	output logic pslverr_out, // apb error
	output logic [1:0] fault_sel_out, // most urgent pending fault
	output logic [2:0] fault_lvl_out, // its level
	output logic [2:0] usage_lvl_out, // usage-fault level
	output logic [2:0] bus_lvl_out, // bus-fault level
	output logic [2:0] mem_lvl_out // memory-management level
);
	// ******************************************************
	// decode
	// ******************************************************
	fhp_level_t usage_r;
	fhp_level_t bus_r;
	fhp_level_t mem_r;
	logic hit;
	logic priv;
	logic acc;
	logic ok;
	logic [31:0] rd_word;
	fhp_rank_if rk_if ();

	assign hit = (paddr_in[`FHP_ADDR_W-1:2] == (`FHP_ADDR_W-2)'(`FHP_OFF_PRIO_ONE >> 2));
	assign priv = pprot_in[`FHP_PRIV_BIT];
	assign acc = psel_in && penable_in;
	assign ok = hit && priv;
	assign pready_out = 1'b1;
	assign pslverr_out = acc && !ok;

	always_comb begin
		rd_word = `FHP_RESET_VAL;
		rd_word[`FHP_USAGE_HI:`FHP_USAGE_LO] = usage_r;
		rd_word[`FHP_BUS_HI:`FHP_BUS_LO] = bus_r;
		rd_word[`FHP_MEM_HI:`FHP_MEM_LO] = mem_r;
	end

	// ******************************************************
	// register fields
	// ******************************************************
	// each field lives in one byte lane, so its strobe alone gates it
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			usage_r <= `FHP_LVL_RESET;
			bus_r <= `FHP_LVL_RESET;
			mem_r <= `FHP_LVL_RESET;
		end else if (acc && pwrite_in && ok) begin
			if (pstrb_in[2]) begin
				usage_r <= pwdata_in[`FHP_USAGE_HI:`FHP_USAGE_LO];
			end
			if (pstrb_in[1]) begin
				bus_r <= pwdata_in[`FHP_BUS_HI:`FHP_BUS_LO];
			end
			if (pstrb_in[0]) begin
				mem_r <= pwdata_in[`FHP_MEM_HI:`FHP_MEM_LO];
			end
		end
	end

	// read data registered at the setup-phase edge (psel high, penable low); refused reads return zero
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prdata_out <= `FHP_RESET_VAL;
		end else if (psel_in && !penable_in) begin
			prdata_out <= (!pwrite_in && ok) ? rd_word : `FHP_RESET_VAL;
		end
	end

	// ******************************************************
	// ranking
	// ******************************************************
	assign rk_if.usage_lvl = usage_r;
	assign rk_if.bus_lvl = bus_r;
	assign rk_if.mem_lvl = mem_r;
	assign rk_if.pending = fault_pend_in;

	fhp_rank i_fhp_rank (
		.rk(rk_if.ranker)
	);

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fault_sel_out <= fhp_src_none;
			fault_lvl_out <= `FHP_LVL_NONE;
		end else begin
			fault_sel_out <= rk_if.winner;
			fault_lvl_out <= rk_if.winner_lvl;
		end
	end

	assign usage_lvl_out = usage_r;
	assign bus_lvl_out = bus_r;
	assign mem_lvl_out = mem_r;
endmodule : fhp_top

/* File: verification/fhp_checker.sv */
// port checker for the fault handler priority block
// assumes binding onto fhp_top
module fhp_checker (
	input wire logic clk_in, // clock
	input wire logic rst_n_in, // reset, active low
	input wire logic psel_in, // apb select
	input wire logic penable_in, // apb enable
	input wire logic pwrite_in, // apb write
	input wire logic [11:0] paddr_in, // address
	input wire logic [31:0] pwdata_in, // write data
	input wire logic [31:0] prdata_out, // read data
	input wire logic [3:0] pstrb_in, // strobes
	input wire logic [2:0] pprot_in, // protection
	input wire logic [2:0] fault_pend_in, // pending
	input wire logic pslverr_out, // error
	input wire logic [1:0] fault_sel_out, // winner
	input wire logic [2:0] usage_lvl_out, // usage level
	input wire logic [2:0] bus_lvl_out, // bus level
	input wire logic [2:0] mem_lvl_out // mem level
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	wire acc = psel_in && penable_in;
	wire wok = acc && pwrite_in && pprot_in[0] && paddr_in[11:2] == 10'h346;
	priv_guard_a: assert property (acc && !pprot_in[0] |-> pslverr_out)
		else $error("unprivileged access taken");
	lane_keep_a: assert property (wok && !pstrb_in[2] |=> $stable(usage_lvl_out))
		else $error("unstrobed lane changed");
	usage_write_a: assert property (wok && pstrb_in[2] |=>
		usage_lvl_out == $past(pwdata_in[23:21])) else $error("usage level wrong");
	rank_order_a: assert property (fault_pend_in == 3'h3 |=>
		fault_sel_out == {1'b0, $past(bus_lvl_out) < $past(usage_lvl_out)})
		else $error("wrong winner");
	bus_mem_a: assert property (wok && pstrb_in[1:0] == 2'h3 |=> {bus_lvl_out, mem_lvl_out}
		== $past({pwdata_in[15:13], pwdata_in[7:5]})) else $error("bus or mem level wrong");
	read_map_a: assert property (acc && !pwrite_in && !pslverr_out |-> prdata_out ==
		{8'h00, usage_lvl_out, 5'h00, bus_lvl_out, 5'h00, mem_lvl_out, 5'h00})
		else $error("read data wrong");
endmodule : fhp_checker
bind fhp_top fhp_checker i_fhp_checker (
	.clk_in(clk_in),
	.rst_n_in(rst_n_in),
	.psel_in(psel_in),
	.penable_in(penable_in),
	.pwrite_in(pwrite_in),
	.paddr_in(paddr_in),
	.pwdata_in(pwdata_in),
	.prdata_out(prdata_out),
	.pstrb_in(pstrb_in),
	.pprot_in(pprot_in),
	.fault_pend_in(fault_pend_in),
	.pslverr_out(pslverr_out),
	.fault_sel_out(fault_sel_out),
	.usage_lvl_out(usage_lvl_out),
	.bus_lvl_out(bus_lvl_out),
	.mem_lvl_out(mem_lvl_out)
);

/* File: verification/fault_handler_priority_reg_test.sv */
// apb bench for the fault handler priority block
// assumes fhp_top with zero wait states allowed but not relied on
module fault_handler_priority_reg_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, en = 1'b0, wr = 1'b0, err, rdy, e;
	logic [11:0] addr = 12'h000;
	logic [31:0] wd = 32'h0000_0000, rd, r;
	logic [3:0] strb = 4'h0;
	logic [2:0] prot = 3'h0, pend = 3'h0, flvl, ul, bl, ml;
	logic [1:0] fsel;
	int error_cnt = 0, total_checks = 0;
	`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin error_cnt++; \
		$display("[ERR] %s exp %h got %h", nm, ex, got); end end
	fhp_top i_fhp_top (.clk_in(clk), .rst_n_in(rst_n), .psel_in(sel), .penable_in(en),
		.pwrite_in(wr), .paddr_in(addr), .pwdata_in(wd), .pstrb_in(strb), .pprot_in(prot),
		.fault_pend_in(pend), .prdata_out(rd), .pready_out(rdy), .pslverr_out(err),
		.fault_sel_out(fsel), .fault_lvl_out(flvl), .usage_lvl_out(ul), .bus_lvl_out(bl),
		.mem_lvl_out(ml));
	always #2.5 clk = ~clk;
	task wrap_up();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// one full transfer; request held until pready is seen
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [2:0] p);
		int n;
		sel <= 1'b1;
		wr <= w;
		addr <= a;
		wd <= d;
		strb <= s;
		prot <= p;
		@(posedge clk);
		en <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (rdy !== 1'b1 && n < 20);
		if (n >= 20) error_cnt++;
		r = rd;
		e = err;
		sel <= 1'b0;
		en <= 1'b0;
		// one idle edge so the next call never reassigns psel in this time step
		@(posedge clk);
	endtask : apb
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, 12'hd18, 32'h0000_0000, 4'h0, 3'h1);
		`CHK("reset", 32'h0000_0000, r)
		apb(1, 12'hd18, 32'hffff_ffff, 4'hf, 3'h1);
		apb(0, 12'hd18, 32'h0000_0000, 4'h0, 3'h1);
		`CHK("all ones", 32'h00e0_e0e0, r)
		`CHK("bus mem", 6'h3f, {bl, ml})
		`CHK("usage", 3'h7, ul)
		`CHK("ready", 1'b1, rdy)
		apb(1, 12'hd18, 32'h0000_0000, 4'h4, 3'h1);
		apb(0, 12'hd18, 32'h0000_0000, 4'h0, 3'h1);
		`CHK("lane two", 32'h0000_e0e0, r)
		apb(1, 12'hd18, 32'h0000_0000, 4'hf, 3'h0);
		`CHK("user err", 1'b1, e)
		apb(0, 12'hd18, 32'h0000_0000, 4'h0, 3'h1);
		`CHK("user kept", 32'h0000_e0e0, r)
		apb(0, 12'hd1c, 32'h0000_0000, 4'h0, 3'h1);
		`CHK("unmapped", 32'h0000_0000, r)
		$display("register test done");
		apb(1, 12'hd18, 32'h00a0_4040, 4'hf, 3'h1);
		pend <= 3'h7;
		repeat (2) @(posedge clk);
		`CHK("winner", 2'h1, fsel)
		`CHK("win lvl", 3'h2, flvl)
		pend <= 3'h3;
		repeat (2) @(posedge clk);
		`CHK("usage bus", 2'h1, fsel)
		pend <= 3'h5;
		repeat (2) @(posedge clk);
		`CHK("usage mem", 2'h2, fsel)
		pend <= 3'h0;
		repeat (2) @(posedge clk);
		`CHK("none", 2'h3, fsel)
		`CHK("none lvl", 3'h7, flvl)
		$display("ranking test done");
		apb(0, 12'hd18, 32'h0000_0000, 4'h0, 3'h1);
		apb(1, 12'hd18, (r & 32'hff1f_ffff) | 32'h0060_0000, 4'hf, 3'h1);
		apb(0, 12'hd18, 32'h0000_0000, 4'h0, 3'h1);
		`CHK("rmw", 32'h0060_4040, r)
		apb(1, 12'hd18, 32'h0000_0000, 4'h3, 3'h1);
		apb(0, 12'hd18, 32'h0000_0000, 4'h0, 3'h1);
		`CHK("low lanes", 32'h0060_0000, r)
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, 12'hd18, 32'h0000_0000, 4'h0, 3'h1);
		`CHK("reset clears", 32'h0000_0000, r)
		`CHK("reset sel", 2'h3, fsel)
		$display("update and reset test done");
		wrap_up();
	end
	initial begin
		#5000;
		error_cnt++;
		wrap_up();
	end
endmodule : fault_handler_priority_reg_test
